//--- design/alss_ctrl_top.sv
// Purpose: converter control with stop handling and Wishbone registers
// Assumes: stop inputs come from the power controller on clk_i
// Notes:   single clock; the asynchronous source is modelled on clk_i
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module alss_ctrl_top
   import alss_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        stop_i,
   input  wire logic        lp_stop_i,
   input  wire logic        hw_trig_i,
   input  wire logic        comp_i,
   output logic      [11:0] dac_o,
   output logic             sampling_o,
   output logic      [4:0]  input_channel_sel_o,
   output logic      [1:0]  vref_pair_sel_o,
   output logic             low_power_cfg_o,
   output logic             dma_req_o,
   output logic             wake_o,
   output logic             irq_o
);
   alss_conv_if cv ();
   alss_sar_core u_core (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cv    (cv.core)
   );

   // low-power stop acts as a module reset, so exit finds reset values
   wire mod_rst = rst_i | lp_stop_i;

   logic [7:0]  chan_q, conversion_config_one_q, sc2_q, sc3_q, irq_st_q, irq_mk_q;
   logic [11:0] thr1_q, thr2_q, result_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   alss_seq_t   seq_q;
   logic [4:0]  avg_q;
   logic [16:0] acc_q;
   logic [11:0] val_q;
   logic [3:0]  div_q;
   logic        stop_q, lock_q;
   logic [2:0]  trg_s_q, cmp_s_q;
   logic        trg_f_q, cmp_f_q, trg_edge_q;

   // pins: three stages, a change counts once stages two and three agree
   always_ff @(posedge clk_i) begin
      trg_s_q    <= {trg_s_q[1:0], hw_trig_i};
      cmp_s_q    <= {cmp_s_q[1:0], comp_i};
      trg_edge_q <= 1'b0;
      if (rst_i) begin
         trg_f_q <= 1'b0;
         cmp_f_q <= 1'b0;
      end else begin
         if (trg_s_q[1] == trg_s_q[2]) begin
            trg_f_q    <= trg_s_q[2];
            trg_edge_q <= trg_s_q[2] & ~trg_f_q;
         end
         if (cmp_s_q[1] == cmp_s_q[2]) begin
            cmp_f_q <= cmp_s_q[2];
         end
      end
   end

   // bus decode
   wire req      = wb_cyc_i & wb_stb_i & ~ack_q;
   wire wr       = req & wb_we_i & wb_sel_i[0];
   wire wr_hi    = req & wb_we_i & wb_sel_i[1];
   wire rd       = req & ~wb_we_i;
   wire hit_chan = (wb_adr_i == OFS_CHAN_CTRL_A);
   wire hit_conversion_config_one = (wb_adr_i == OFS_CONV_CONVERSION_CONFIG_ONE);
   wire hit_sc2  = (wb_adr_i == OFS_STAT_CTRL2);
   wire hit_sc3  = (wb_adr_i == OFS_STAT_CTRL3);
   wire hit_thr1 = (wb_adr_i == OFS_CMP_THR1);
   wire hit_thr2 = (wb_adr_i == OFS_CMP_THR2);
   wire hit_res  = (wb_adr_i == OFS_RESULT_A);
   wire hit_ist  = (wb_adr_i == OFS_IRQ_STATUS);
   wire hit_imk  = (wb_adr_i == OFS_IRQ_MASK);

   // fields
   wire        async_sel = (conversion_config_one_q[CF_ICLK +: 2] == ICLK_ASYNC);
   wire [1:0]  mode      = conversion_config_one_q[CF_MODE +: 2];
   wire        hw_trg    = sc2_q[S2_TRG];
   wire        cmp_en    = sc2_q[S2_CFE];
   wire        cmp_gt    = sc2_q[S2_CGT];
   wire        cmp_rng   = sc2_q[S2_CRE];
   wire        cont      = sc3_q[S3_CONT];
   wire        avg_en    = sc3_q[S3_AVGE];
   wire [1:0]  avg_sel   = sc3_q[S3_AVGS +: 2];
   wire        chan_on   = (chan_q[4:0] != CHAN_OFF);

   // conversion clock stops in normal stop unless the async source runs
   wire conv_run  = ~stop_i | async_sel;
   wire stop_rise = stop_i & ~stop_q;
   wire abort     = stop_rise & ~async_sel & (seq_q != SEQ_IDLE);

   // divider: 1,2,4,8
   // bus/2 shares this divider, it is not halved again
   wire [3:0] div_lim = (4'h1 << conversion_config_one_q[CF_DIV +: 2])
                        - 4'h1;
   wire       div_end = (div_q == div_lim);
   assign cv.tick     = conv_run & div_end;
   assign cv.nbits    = (mode == MODE_8BIT)  ? 4'd8 :
                        (mode == MODE_10BIT) ? 4'd10 : 4'd12;
   assign cv.long_smp = conversion_config_one_q[CF_LS];
   assign cv.comp     = cmp_f_q;
   assign cv.abort    = abort | lp_stop_i;

   // triggers: software by writing the channel byte, else hardware edge
   wire sw_go  = wr & hit_chan & ~hw_trg & (wb_dat_i[4:0] != CHAN_OFF);
   wire hw_go  = trg_edge_q & hw_trg & chan_on & conv_run;
   wire go     = (sw_go | hw_go) & ~lp_stop_i;

   // averaging: 4,8,16,32 samples
   wire [4:0]  avg_last = (5'h04 << avg_sel) - 5'h01;
   wire [16:0] acc_sum  = acc_q + {5'h00, cv.result};
   wire [16:0] avg_val  = acc_sum >> (3'd2 + {1'b0, avg_sel});
   wire        more     = avg_en & (avg_q != avg_last);

   // compare: below / at-or-above, or inside / outside a range
   wire ge1     = (val_q >= thr1_q);
   wire le2     = (val_q <= thr2_q);
   wire in_rng  = (thr1_q <= thr2_q) ? (ge1 & le2) : (ge1 | le2);
   wire cmp_hit = cmp_rng ? (cmp_gt ? in_rng : ~in_rng)
                          : (cmp_gt ? ge1 : ~ge1);
   wire cmp_ok  = ~cmp_en | cmp_hit;
   wire eval    = (seq_q == SEQ_EVAL);
   wire done_ev = eval & cmp_ok;
   // one clock domain here, so the flag and result are already local
   wire flag_set = done_ev;
   wire restart  = eval & cont & chan_on & conv_run;

   assign cv.start = (go & (seq_q == SEQ_IDLE))
                     | ((seq_q == SEQ_RUN) & cv.done & more)
                     | restart;

   // sequencer
   always_ff @(posedge clk_i) begin
      if (mod_rst || abort) begin
         seq_q <= SEQ_IDLE;
         avg_q <= 5'h00;
         acc_q <= 17'h00000;
         val_q <= RST_REG12;
      end else begin
         unique case (seq_q)
            SEQ_IDLE: begin
               if (go) begin
                  avg_q <= 5'h00;
                  acc_q <= 17'h00000;
                  seq_q <= SEQ_RUN;
               end
            end
            SEQ_RUN: begin
               if (cv.done) begin
                  if (more) begin
                     acc_q <= acc_sum;
                     avg_q <= avg_q + 5'h01;
                  end else begin
                     val_q <= avg_en ? avg_val[11:0] : cv.result;
                     seq_q <= SEQ_EVAL;
                  end
               end
            end
            SEQ_EVAL: begin
               avg_q <= 5'h00;
               acc_q <= 17'h00000;
               // single mode with a compare miss just goes idle
               seq_q <= restart ? SEQ_RUN : SEQ_IDLE;
            end
            default: seq_q <= SEQ_IDLE;
         endcase
      end
   end

   // divider and stop tracking
   always_ff @(posedge clk_i) begin
      if (mod_rst) begin
         div_q  <= 4'h0;
         stop_q <= 1'b0;
      end else begin
         stop_q <= stop_i;
         div_q  <= (div_end || !conv_run) ? 4'h0 : div_q + 4'h1;
      end
   end

   // result: in stop only the first completion is kept
   always_ff @(posedge clk_i) begin
      if (mod_rst) begin
         result_q <= RST_REG12;
         lock_q   <= 1'b0;
      end else begin
         if (done_ev && !lock_q) begin
            result_q <= val_q;
         end
         if (!stop_i) begin
            lock_q <= 1'b0;
         end else if (done_ev) begin
            lock_q <= 1'b1;
         end
      end
   end

   // registers; stop itself touches none of them
   wire chan_clr = (wr & hit_chan) | (rd & hit_res);
   always_ff @(posedge clk_i) begin
      if (mod_rst) begin
         chan_q <= RST_REG8;
         conversion_config_one_q <= RST_REG8;
         sc2_q  <= RST_REG8;
         sc3_q  <= RST_REG8;
         thr1_q <= RST_REG12;
         thr2_q <= RST_REG12;
      end else begin
         if (wr && hit_chan) begin
            chan_q[6:0] <= {wb_dat_i[6], 1'b0, wb_dat_i[4:0]};
         end
         // completion flag: a set in the clearing cycle wins
         if (flag_set) begin
            chan_q[CC_FLAG] <= 1'b1;
         end else if (chan_clr) begin
            chan_q[CC_FLAG] <= 1'b0;
         end
         if (wr && hit_conversion_config_one) begin
            conversion_config_one_q <= wb_dat_i[7:0];
         end
         if (wr && hit_sc2) begin
            sc2_q[6:0] <= wb_dat_i[6:0];
         end
         if (wr && hit_sc3) begin
            sc3_q <= {4'h0, wb_dat_i[3:0]};
         end
         if (wr && hit_thr1) begin
            thr1_q[7:0] <= wb_dat_i[7:0];
         end
         if (wr_hi && hit_thr1) begin
            thr1_q[11:8] <= wb_dat_i[11:8];
         end
         if (wr && hit_thr2) begin
            thr2_q[7:0] <= wb_dat_i[7:0];
         end
         if (wr_hi && hit_thr2) begin
            thr2_q[11:8] <= wb_dat_i[11:8];
         end
         sc2_q[S2_ACT] <= (seq_q != SEQ_IDLE) | cv.start;
      end
   end

   // interrupt status, write one to clear, set wins
   wire [7:0] ist_set = {6'h00, abort, flag_set};
   wire [7:0] ist_clr = (wr & hit_ist) ? wb_dat_i[7:0] : 8'h00;
   always_ff @(posedge clk_i) begin
      if (mod_rst) begin
         irq_st_q <= RST_REG8;
         irq_mk_q <= RST_REG8;
      end else begin
         irq_st_q <= (irq_st_q & ~ist_clr) | ist_set;
         if (wr && hit_imk) begin
            irq_mk_q <= {6'h00, wb_dat_i[1:0]};
         end
      end
   end

   // read mux, zero for unmapped
   wire [31:0] rmux =
      hit_chan ? {24'h0, chan_q} :
      hit_conversion_config_one ? {24'h0, conversion_config_one_q} :
      hit_sc2  ? {24'h0, sc2_q} :
      hit_sc3  ? {24'h0, sc3_q} :
      hit_thr1 ? {20'h0, thr1_q} :
      hit_thr2 ? {20'h0, thr2_q} :
      hit_res  ? {20'h0, result_q} :
      hit_ist  ? {24'h0, irq_st_q} :
      hit_imk  ? {24'h0, irq_mk_q} : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= req;
         rdat_q <= rd ? rmux : 32'h0000_0000;
      end
   end

   assign wb_ack_o            = ack_q;
   assign wb_dat_o            = rdat_q;
   assign dac_o               = cv.dac;
   assign sampling_o          = cv.sampling;
   assign input_channel_sel_o = chan_q[4:0];
   assign vref_pair_sel_o     = sc2_q[1:0];
   assign low_power_cfg_o     = conversion_config_one_q[CF_LP];
   assign dma_req_o           = chan_q[CC_FLAG] & sc2_q[S2_DMA];
   // wake request to the power controller while flag and enable are set
   assign wake_o              = chan_q[CC_FLAG] & chan_q[CC_IEN];
   assign irq_o               = |(irq_st_q & irq_mk_q);
endmodule

//--- design/alss_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes:   all registers reset to zero
package alss_pkg;
   localparam logic [7:0] OFS_CHAN_CTRL_A = 8'h00;
   localparam logic [7:0] OFS_CONV_CONVERSION_CONFIG_ONE   = 8'h04;
   localparam logic [7:0] OFS_STAT_CTRL2  = 8'h08;
   localparam logic [7:0] OFS_STAT_CTRL3  = 8'h0C;
   localparam logic [7:0] OFS_CMP_THR1    = 8'h10;
   localparam logic [7:0] OFS_RESULT_A    = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h1C;
   localparam logic [7:0] OFS_CMP_THR2    = 8'h20;
   localparam logic [7:0]  RST_REG8   = 8'h00;
   localparam logic [11:0] RST_REG12  = 12'h000;
   localparam logic [4:0]  CHAN_OFF   = 5'h1F;
   // channel_control_a fields
   localparam int CC_FLAG = 7;
   localparam int CC_IEN  = 6;
   // conversion_config_one fields
   localparam int CF_LP   = 7;
   localparam int CF_DIV  = 5;
   localparam int CF_LS   = 4;
   localparam int CF_MODE = 2;
   localparam int CF_ICLK = 0;
   localparam logic [1:0] ICLK_BUS_DIV2 = 2'h1;
   localparam logic [1:0] ICLK_ASYNC    = 2'h3;
   localparam logic [1:0] MODE_8BIT     = 2'h0;
   localparam logic [1:0] MODE_10BIT    = 2'h2;
   // status_control_two fields
   localparam int S2_ACT = 7;
   localparam int S2_TRG = 6;
   localparam int S2_CFE = 5;
   localparam int S2_CGT = 4;
   localparam int S2_CRE = 3;
   localparam int S2_DMA = 2;
   // status_control_three fields
   localparam int S3_CONT = 3;
   localparam int S3_AVGE = 2;
   localparam int S3_AVGS = 0;
   // irq status bits
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_ABORT = 1;
   // sample window in conversion clock ticks
   localparam logic [4:0] SAMPLE_SHORT = 5'h04;
   localparam logic [4:0] SAMPLE_LONG  = 5'h18;
   typedef enum logic [1:0] {
      CORE_IDLE   = 2'b00,
      CORE_SAMPLE = 2'b01,
      CORE_SAR    = 2'b10
   } alss_core_t;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_RUN  = 2'b01,
      SEQ_EVAL = 2'b10
   } alss_seq_t;
endpackage

//--- design/alss_conv_if.sv
// Purpose: link between sequencer and successive-approximation core
// Assumes: single clock
// Notes:   start is a one-cycle pulse; abort also stays high for as long as lp_stop_i is held
`timescale 1ns/1ps
interface alss_conv_if;
   logic        start;
   logic        abort;
   logic        tick;
   logic [3:0]  nbits;
   logic        long_smp;
   logic        comp;
   logic        busy;
   logic        done;
   logic [11:0] result;
   logic [11:0] dac;
   logic        sampling;
   modport core (input start, abort, tick, nbits, long_smp, comp,
                 output busy, done, result, dac, sampling);
   modport ctrl (output start, abort, tick, nbits, long_smp, comp,
                 input busy, done, result, dac, sampling);
endinterface

//--- design/alss_sar_core.sv
// Purpose: sample then successive approximation, one bit per tick
// Assumes: comp high means input at or above dac code
// Notes:   abort returns to idle at once, result kept
`timescale 1ns/1ps
module alss_sar_core
   import alss_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   alss_conv_if.core cv
);
   alss_core_t  state_q;
   logic [4:0]  cnt_q;
   logic [3:0]  bit_q;
   logic [11:0] code_q;
   logic [11:0] res_q;
   logic        done_q;
   wire  [11:0] one_hot  = 12'h001 << bit_q;
   wire  [11:0] kept     = cv.comp ? code_q : (code_q & ~one_hot);
   wire  [11:0] next_try = kept | (one_hot >> 1);

   assign cv.busy     = (state_q != CORE_IDLE);
   assign cv.done     = done_q;
   assign cv.result   = res_q;
   assign cv.dac      = code_q;
   assign cv.sampling = (state_q == CORE_SAMPLE);

   always_ff @(posedge clk_i) begin
      done_q <= 1'b0;
      if (rst_i || cv.abort) begin
         state_q <= CORE_IDLE;
         cnt_q   <= 5'h00;
         bit_q   <= 4'h0;
         code_q  <= 12'h000;
         if (rst_i) begin
            res_q <= RST_REG12;
         end
      end else begin
         unique case (state_q)
            CORE_IDLE: begin
               if (cv.start) begin
                  cnt_q   <= cv.long_smp ? SAMPLE_LONG : SAMPLE_SHORT;
                  state_q <= CORE_SAMPLE;
               end
            end
            CORE_SAMPLE: begin
               if (cv.tick) begin
                  if (cnt_q == 5'h01) begin
                     bit_q   <= cv.nbits - 4'h1;
                     code_q  <= 12'h001 << (cv.nbits - 4'h1);
                     state_q <= CORE_SAR;
                  end else begin
                     cnt_q <= cnt_q - 5'h01;
                  end
               end
            end
            CORE_SAR: begin
               if (cv.tick) begin
                  if (bit_q == 4'h0) begin
                     res_q   <= kept;
                     code_q  <= 12'h000;
                     done_q  <= 1'b1;
                     state_q <= CORE_IDLE;
                  end else begin
                     code_q <= next_try;
                     bit_q  <= bit_q - 4'h1;
                  end
               end
            end
            default: state_q <= CORE_IDLE;
         endcase
      end
   end
endmodule

//--- verification/alss_ctrl_chk.sv
// Purpose: port-level checks of the converter control block
// Assumes: single clock, synchronous reset
// Notes:   clock source and interrupt enable are tracked from acked writes
`timescale 1ns/1ps
module alss_ctrl_chk
   import alss_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        stop_i,
   input wire logic        lp_stop_i,
   input wire logic        hw_trig_i,
   input wire logic        comp_i,
   input wire logic [11:0] dac_o,
   input wire logic        sampling_o,
   input wire logic [4:0]  input_channel_sel_o,
   input wire logic [1:0]  vref_pair_sel_o,
   input wire logic        low_power_cfg_o,
   input wire logic        dma_req_o,
   input wire logic        wake_o,
   input wire logic        irq_o
);
   logic [1:0] iclk_q;
   logic       ien_q;
   wire logic  wr_w = wb_ack_o && wb_we_i && wb_sel_i[0];
   always_ff @(posedge clk_i) begin
      if (rst_i || lp_stop_i) begin
         iclk_q <= 2'h0;
         ien_q  <= 1'b0;
      end else if (wr_w && wb_adr_i == OFS_CONV_CONVERSION_CONFIG_ONE) begin
         iclk_q <= wb_dat_i[1:0];
      end else if (wr_w && wb_adr_i == OFS_CHAN_CTRL_A) begin
         ien_q <= wb_dat_i[CC_IEN];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   AST_ACK_RESP: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   AST_LP_CLEAR: assert property (
      lp_stop_i |=> !wake_o && !irq_o && !dma_req_o && !low_power_cfg_o
                    && input_channel_sel_o == 5'h00 && vref_pair_sel_o == 2'h0)
      else $error("low-power stop left state behind");
   AST_STOP_HOLD: assert property (
      stop_i && !wb_cyc_i && !lp_stop_i ##1 !wb_cyc_i && !lp_stop_i
      |-> $stable(input_channel_sel_o) && $stable(vref_pair_sel_o)
          && $stable(low_power_cfg_o))
      else $error("register output changed during stop");
   AST_STOP_ABORT: assert property (
      stop_i && iclk_q != ICLK_ASYNC |-> ##[0:3] !sampling_o)
      else $error("stop without async clock did not abort");
   AST_IDLE_AFTER: assert property (
      $fell(stop_i) && iclk_q != ICLK_ASYNC && !wb_cyc_i |-> !sampling_o [*2])
      else $error("converter restarted without trigger");
   AST_WAKE_EN: assert property (wake_o |-> ien_q)
      else $error("wake raised with interrupt disabled");
   AST_CHSEL: assert property (
      wr_w && wb_adr_i == OFS_CHAN_CTRL_A && !lp_stop_i
      |=> input_channel_sel_o == $past(wb_dat_i[4:0]))
      else $error("channel select not taken from write");
   AST_VREF: assert property (
      wr_w && wb_adr_i == OFS_STAT_CTRL2 && !lp_stop_i
      |=> vref_pair_sel_o == $past(wb_dat_i[1:0]))
      else $error("reference pair not taken from write");
   AST_LPCFG: assert property (
      wr_w && wb_adr_i == OFS_CONV_CONVERSION_CONFIG_ONE && !lp_stop_i
      |=> low_power_cfg_o == $past(wb_dat_i[CF_LP]))
      else $error("low power bit not taken from write");
   COV_WAKE: cover property (wake_o);
   COV_IRQ: cover property (irq_o);
   COV_STOP_RUN: cover property (stop_i && sampling_o);
endmodule
bind alss_ctrl_top alss_ctrl_chk CHK (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stop_i, .lp_stop_i, .hw_trig_i,
   .comp_i, .dac_o, .sampling_o, .input_channel_sel_o, .vref_pair_sel_o,
   .low_power_cfg_o, .dma_req_o, .wake_o, .irq_o);

//--- verification/alss_analog_model.sv
// Purpose: analog input and hardware trigger source facing the converter
// Assumes: only channel 1 carries a level, other channels sit at ground
// Notes:   trigger is held four cycles so the pin synchroniser sees an edge
`timescale 1ns/1ps
module alss_analog_model
   import alss_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic [11:0] dac_i,
   input  wire logic [4:0]  chan_i,
   input  wire logic [11:0] level_i,
   input  wire logic        fire_i,
   output logic             comp_o,
   output logic             trig_o
);
   logic [2:0]  hold_q = 3'h0;
   wire logic [11:0] vin_w = (chan_i == 5'h01) ? level_i : 12'h000;
   assign comp_o = vin_w >= dac_i;
   assign trig_o = hold_q != 3'h0;
   always @(posedge clk_i) begin
      if (fire_i) hold_q <= 3'h4;
      else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
   end
endmodule

//--- verification/adc_lowpower_stop_and_setup_bench.sv
// Purpose: self-checking bench of the converter control block
// Assumes: divide by 8 leaves the comparator synchroniser time to settle
// Notes:   register model is an array updated on every acked write
`timescale 1ns/1ps
module adc_lowpower_stop_and_setup_bench;
   import alss_pkg::*;
   localparam int CONV = 128;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, stop_i, lp_stop_i, fire;
   logic hw_trig_i, comp_i, wb_ack_o, sampling_o, low_power_cfg_o, dma_req_o, wake_o, irq_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [11:0] dac_o, lvl;
   logic [4:0]  input_channel_sel_o;
   logic [1:0]  vref_pair_sel_o;
   logic [31:0] mdl [9];
   int          error_cnt, tests_run, cc;
   alss_ctrl_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .stop_i, .lp_stop_i, .hw_trig_i, .comp_i, .dac_o,
      .sampling_o, .input_channel_sel_o, .vref_pair_sel_o, .low_power_cfg_o, .dma_req_o,
      .wake_o, .irq_o);
   alss_analog_model AM (.clk_i, .dac_i(dac_o), .chan_i(input_channel_sel_o),
      .level_i(lvl), .fire_i(fire), .comp_o(comp_i), .trig_o(hw_trig_i));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cc <= cc + 1;
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] expv);
      tests_run++;
      if (got !== expv) begin
         error_cnt++;
         $display("Error t=%0t got %h exp %h", $time, got, expv);
      end
   endtask
   function automatic void mupd(input logic [7:0] a, input logic [31:0] d);
      int i;
      i = int'(a) / 4;
      if (a == OFS_CHAN_CTRL_A || a == OFS_STAT_CTRL2) mdl[i] = d & 32'h0000_007F;
      else if (a == OFS_CMP_THR1 || a == OFS_CMP_THR2) mdl[i] = d & 32'h0000_0FFF;
      else if (a == OFS_IRQ_STATUS) mdl[i] = mdl[i] & ~d;
      else if (a != OFS_RESULT_A && i < 9) mdl[i] = d & 32'h0000_00FF;
   endfunction
   function automatic logic hitf(input logic gt, input logic rg, input int r, input int t1,
                                 input int t2);
      if (!rg) return gt ? r >= t1 : r < t1;
      return gt ? (r >= t1 && r <= t2) : (r < t1 || r > t2);
   endfunction
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         error_cnt++;
         report_and_stop();
      end
      if (we) mupd(a, d);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      chk(q, e);
   endtask
   task automatic regs;
      for (int i = 0; i < 9; i++) rchk(8'(i * 4), mdl[i]);
   endtask
   task automatic poll(input int lim, output int el, output logic hit);
      logic [31:0] q;
      int t0;
      t0 = cc;
      hit = 1'b0;
      while (!hit && cc - t0 < lim) begin
         wb(1'b0, OFS_CHAN_CTRL_A, 32'h0000_0000, q);
         hit = (q[CC_FLAG] === 1'b1);
      end
      el = cc - t0;
   endtask
   task automatic go(input logic [11:0] v, input logic hw, input logic want, output int el);
      logic h;
      @(posedge clk_i);
      lvl <= v;
      wr(OFS_CHAN_CTRL_A, 32'h0000_0041);
      if (hw) begin
         fire <= 1'b1;
         @(posedge clk_i);
         fire <= 1'b0;
      end
      poll(want ? 2000 : 400, el, h);
      chk(32'(h), 32'(want));
      if (h) begin
         chk(32'(wake_o), 32'h0000_0001);
         chk(32'(dma_req_o), 32'(mdl[2][S2_DMA]));
         rchk(OFS_RESULT_A, 32'(v));
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   initial begin
      int el;
      logic h;
      logic [11:0] v, w;
      {wb_cyc_i, wb_stb_i, wb_we_i, stop_i, lp_stop_i, fire} = 6'h00;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      lvl = 12'h000;
      error_cnt = 0;
      tests_run = 0;
      foreach (mdl[i]) mdl[i] = 32'h0000_0000;
      void'($urandom(92));
      rst_i = 1'b1;
      idle(12);
      rst_i <= 1'b0;
      regs();
      wr(8'h40, 32'h0000_00FF);
      rchk(8'h40, 32'h0000_0000);
      $display("test reset done");
      wr(OFS_CONV_CONVERSION_CONFIG_ONE, 32'h0000_0098);
      wr(OFS_STAT_CTRL2, 32'h0000_00FF);
      wr(OFS_STAT_CTRL3, 32'h0000_000F);
      wr(OFS_CHAN_CTRL_A, 32'h0000_005F);
      wr(OFS_CMP_THR1, 32'h0000_0ABC);
      wr(OFS_CMP_THR2, 32'h0000_0123);
      wr(OFS_RESULT_A, 32'h0000_0FFF);
      regs();
      chk(32'(vref_pair_sel_o), 32'h0000_0003);
      chk(32'(low_power_cfg_o), 32'h0000_0001);
      chk(32'(input_channel_sel_o), 32'h0000_001F);
      $display("test layout done");
      wr(OFS_STAT_CTRL2, 32'h0000_0000);
      wr(OFS_STAT_CTRL3, 32'h0000_0000);
      wr(OFS_CONV_CONVERSION_CONFIG_ONE, 32'h0000_0064);
      v = 12'($urandom_range(16, 4000));
      go(v, 1'b0, 1'b1, el);
      chk(32'(el < 2 * CONV), 32'h0000_0001);
      rchk(OFS_IRQ_STATUS, 32'h0000_0001);
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      idle(2);
      chk(32'(irq_o), 32'h0000_0001);
      wr(OFS_IRQ_MASK, 32'h0000_0000);
      idle(2);
      chk(32'(irq_o), 32'h0000_0000);
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      wr(OFS_IRQ_STATUS, 32'h0000_0001);
      idle(2);
      chk(32'(irq_o), 32'h0000_0000);
      $display("test conversion done");
      w = 12'($urandom_range(16, 4000));
      @(posedge clk_i);
      lvl <= w;
      wr(OFS_CHAN_CTRL_A, 32'h0000_0041);
      idle(30);
      stop_i <= 1'b1;
      idle(10);
      stop_i <= 1'b0;
      rchk(OFS_IRQ_STATUS, 32'h0000_0002);
      poll(600, el, h);
      chk(32'(h), 32'h0000_0000);
      rchk(OFS_RESULT_A, 32'(v));
      wr(OFS_IRQ_STATUS, 32'h0000_0002);
      go(w, 1'b0, 1'b1, el);
      $display("test abort done");
      wr(OFS_STAT_CTRL3, 32'h0000_0004);
      go(w, 1'b0, 1'b1, el);
      chk(32'(el > 3 * CONV), 32'h0000_0001);
      wr(OFS_STAT_CTRL3, 32'h0000_0000);
      $display("test averaging done");
      for (int k = 0; k < 8; k++) begin
         logic [31:0] t1, t2, s2;
         t1 = k[2] ? 32'(v) - 3 : 32'(v) + 1;
         t2 = k[2] ? 32'(v) : 32'(v) + 5;
         s2 = {24'h00_0000, 3'b011, k[0], k[1], 3'b000};
         wr(OFS_STAT_CTRL2, s2);
         wr(OFS_CMP_THR1, t1);
         wr(OFS_CMP_THR2, t2);
         go(v, 1'b1, hitf(k[0], k[1], int'(v), int'(t1), int'(t2)), el);
         rchk(OFS_STAT_CTRL2, mdl[2]);
      end
      wr(OFS_STAT_CTRL2, 32'h0000_0000);
      $display("test compare done");
      wr(OFS_CONV_CONVERSION_CONFIG_ONE, 32'h0000_0067);
      wr(OFS_STAT_CTRL3, 32'h0000_0008);
      @(posedge clk_i);
      lvl <= v;
      wr(OFS_CHAN_CTRL_A, 32'h0000_0041);
      idle(20);
      stop_i <= 1'b1;
      poll(2000, el, h);
      chk(32'(h), 32'h0000_0001);
      @(posedge clk_i);
      lvl <= ~v;
      idle(300);
      rchk(OFS_RESULT_A, 32'(v));
      stop_i <= 1'b0;
      wr(OFS_STAT_CTRL3, 32'h0000_0000);
      $display("test async stop done");
      lp_stop_i <= 1'b1;
      idle(3);
      lp_stop_i <= 1'b0;
      foreach (mdl[i]) mdl[i] = 32'h0000_0000;
      regs();
      wr(OFS_CONV_CONVERSION_CONFIG_ONE, 32'h0000_0067);
      wr(OFS_STAT_CTRL2, 32'h0000_0044);
      stop_i <= 1'b1;
      go(w, 1'b1, 1'b1, el);
      stop_i <= 1'b0;
      $display("test low-power stop done");
      report_and_stop();
   end
endmodule
